// file: inc/srl_pkg.sv
// srl_pkg: shared constants for the serial ram loader link, both ends
// assumes: one 100 MHz clock for both ends; uart framing modelled as byte strobes
package srl_pkg;
   // protocol bytes
   localparam logic [7:0] MATCH_BYTE    = 8'h5a;
   localparam logic [7:0] OP_RAM_LOAD   = 8'h60;
   localparam logic [7:0] ERR_BAUD      = 8'h62;
   localparam logic [7:0] ERR_OPCMD     = 8'h63;
   localparam logic [7:0] ERR_FRAME_A1  = 8'ha1;
   localparam logic [7:0] ERR_FRAME_A3  = 8'ha3;
   localparam logic [7:0] START_MARK    = 8'h3a;
   localparam logic [7:0] BLANK_FILL    = 8'hff;
   localparam logic [7:0] BAUD_9600     = 8'h28;
   // record types
   localparam logic [7:0] REC_DATA      = 8'h00;
   localparam logic [7:0] REC_END       = 8'h01;
   // memory map
   localparam int         ADDR_W        = 16;
   localparam int         RAM_W         = 10;
   localparam int         RAM_DEPTH     = 1024;
   localparam int         PW_MAX        = 16;
   localparam logic [15:0] BLANK_LO     = 16'hffe0;
   localparam logic [15:0] BLANK_HI     = 16'hffff;
   // controller idle cycles after the last address byte; covers the 32-cycle blank scan
   localparam logic [15:0] SCAN_WAIT    = 16'h0028;
   // repeated error code count
   localparam logic [1:0] ERR_REPEAT    = 2'h3;
   // uart bit rates and the clock
   localparam int         CLK_HZ        = 100000000;
   localparam int         INIT_BPS      = 9600;
   localparam int         INIT_DIV      = CLK_HZ / INIT_BPS;
   localparam logic [15:0] INIT_DIV_W   = 16'(INIT_DIV);
endpackage : srl_pkg

// file: inc/srl_if.sv
// srl_if: byte-level link between external controller and the loader device
// assumes: byte strobes stand for uart frames at the current bit rate
`timescale 1ns/1ps
interface srl_if;
   logic       h2d_valid;   // controller byte strobe
   logic [7:0] h2d_data;
   logic       h2d_err;     // framing or parity fault on that byte
   logic       d2h_valid;   // device byte strobe
   logic [7:0] d2h_data;
   logic       d2h_busy;    // device transmitter busy
   logic [15:0] baud_div;   // device current bit divider, for the controller
   modport dev  (input h2d_valid, h2d_data, h2d_err,
                 output d2h_valid, d2h_data, d2h_busy, baud_div);
   modport ctrl (output h2d_valid, h2d_data, h2d_err,
                 input d2h_valid, d2h_data, d2h_busy, baud_div);
endinterface : srl_if

// file: hw/srl_dev.sv
// srl_dev: loader device end; accepts a ram image over the byte link and runs it
// assumes: link bytes arrive one at a time as strobes; rom and security are inputs
// Behaviour
// (R1) echo 5AH on match, silent otherwise
// (R2) echo baud code, else error thrice, halt
// (R3) echo 60H, else 63H thrice, halt; a receive fault on the command byte sends A3H thrice instead
// (R4) count address bytes get no reply
// (R5) compare address bytes get no reply
// (R6) receive error in password phase halts
// (R7) blank top area skips password compare
// (R8) password mismatch halts until pin reset
// (R9) security enabled halts the session
// (R10) controller never sends lone end record
// (R11) discard bytes until start mark
// (R12) parse length, address, type, data, checksum
// (R13) no echo during record phase
// (R14) record phase error halts silently
// (R15) checksum only after clean end record
// (R16) controller waits for checksum reply
// (R17) send checksum upper then lower byte
// (R18) controller judges load by checksum
// (R19) jump to first data record address
// (R20) controller resends match byte until echoed
// (R21) new baud only after echo sent
`timescale 1ns/1ps
module srl_dev (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // link
   srl_if.dev               lnk,
   // device side
   input  wire logic        secure_en,
   input  wire logic [7:0]  rom_byte,
   output logic [15:0]      rom_addr,
   output logic             halted,
   output logic             run_go,
   output logic [15:0]      run_addr,
   output logic [15:0]      image_checksum_word
);
   typedef enum logic [11:0] {
      S_MATCH = 12'h001, S_BAUD = 12'h002, S_CMD = 12'h004, S_PADR = 12'h008,
      S_BLANK = 12'h010, S_PCNT = 12'h020, S_PW   = 12'h040, S_HUNT = 12'h080,
      S_REC   = 12'h100, S_SUMH = 12'h200, S_ERR  = 12'h400, S_HALT = 12'h800
   } srl_state_t;
   srl_state_t  st_r, st_nxt;
   logic [7:0]  ram [0:srl_pkg::RAM_DEPTH-1];   // loaded image
   logic [2:0]  idx_r, idx_nxt;
   logic [15:0] pcnt_adr_r, pcnt_adr_nxt, pcmp_adr_r, pcmp_adr_nxt;
   logic [7:0]  pw_n_r, pw_n_nxt;
   logic [15:0] rom_addr_r, rom_addr_nxt;
   logic [7:0]  reclen_r, reclen_nxt, rtype_r, rtype_nxt, rsum_r, rsum_nxt;
   logic [15:0] radr_r, radr_nxt, sum_r, sum_nxt, first_r, first_nxt;
   logic        have_first_r, have_first_nxt, blank_r, blank_nxt;
   logic [7:0]  tx_r, tx_nxt;
   logic        txv_r, txv_nxt, go_r, go_nxt;
   logic [1:0]  ecnt_r, ecnt_nxt;
   logic [7:0]  err_code_r, err_code_nxt;
   logic [15:0] div_r, div_nxt;
   logic [15:0] pend_div_r, pend_div_nxt;
   logic        pend_r, pend_nxt;
   logic        halted_r, halted_nxt;
   logic        we;
   logic [7:0]  b;

   assign b  = lnk.h2d_data;
   assign we = (st_r == S_REC) && lnk.h2d_valid && !lnk.h2d_err && idx_r == 3'h4
               && rtype_r == srl_pkg::REC_DATA;

   // image store: written only from data record bytes
   always_ff @(posedge clk) begin
      if (we) begin
         ram[radr_r[srl_pkg::RAM_W-1:0]] <= b; // R12
      end
   end

   // protocol sequencer next state
   always_comb begin
      st_nxt = st_r; idx_nxt = idx_r; pcnt_adr_nxt = pcnt_adr_r;
      pcmp_adr_nxt = pcmp_adr_r; pw_n_nxt = pw_n_r; rom_addr_nxt = rom_addr_r;
      reclen_nxt = reclen_r; rtype_nxt = rtype_r; rsum_nxt = rsum_r;
      radr_nxt = radr_r; sum_nxt = sum_r; first_nxt = first_r;
      have_first_nxt = have_first_r; blank_nxt = blank_r; tx_nxt = tx_r;
      txv_nxt = 1'b0; go_nxt = go_r; ecnt_nxt = ecnt_r; err_code_nxt = err_code_r;
      div_nxt = div_r; pend_div_nxt = pend_div_r; pend_nxt = pend_r;
      // baud switch waits for the echo to leave the transmitter
      if (pend_r && !txv_r) begin
         div_nxt = pend_div_r; // R21
         pend_nxt = 1'b0;
      end
      case (st_r)
         S_MATCH: begin
            if (lnk.h2d_valid && !lnk.h2d_err && b == srl_pkg::MATCH_BYTE) begin
               tx_nxt = srl_pkg::MATCH_BYTE; txv_nxt = 1'b1; st_nxt = S_BAUD; // R1
            end
         end
         S_BAUD: begin
            if (lnk.h2d_valid) begin
               if (lnk.h2d_err) begin
                  err_code_nxt = srl_pkg::ERR_FRAME_A1; st_nxt = S_ERR; // R2
               end else if (b == srl_pkg::BAUD_9600) begin
                  tx_nxt = b; txv_nxt = 1'b1; st_nxt = S_CMD;
                  pend_nxt = 1'b1; pend_div_nxt = srl_pkg::INIT_DIV_W; // R21
               end else begin
                  err_code_nxt = srl_pkg::ERR_BAUD; st_nxt = S_ERR; // R2
               end
            end
         end
         S_CMD: begin
            if (lnk.h2d_valid) begin
               if (lnk.h2d_err) begin
                  err_code_nxt = srl_pkg::ERR_FRAME_A3; st_nxt = S_ERR;
               end else if (b == srl_pkg::OP_RAM_LOAD) begin
                  tx_nxt = b; txv_nxt = 1'b1; idx_nxt = 3'h0; st_nxt = S_PADR; // R3
               end else begin
                  err_code_nxt = srl_pkg::ERR_OPCMD; st_nxt = S_ERR; // R3
               end
            end
         end
         S_PADR: begin
            // four address bytes, none answered
            if (lnk.h2d_valid) begin
               if (lnk.h2d_err) st_nxt = S_HALT; // R6
               else begin
                  case (idx_r)
                     3'h0: pcnt_adr_nxt[15:8] = b; // R4
                     3'h1: pcnt_adr_nxt[7:0]  = b; // R4
                     3'h2: pcmp_adr_nxt[15:8] = b; // R5
                     default: pcmp_adr_nxt[7:0] = b; // R5
                  endcase
                  idx_nxt = idx_r + 3'h1;
                  if (idx_r == 3'h3) begin
                     st_nxt = secure_en ? S_HALT : S_BLANK; // R9
                     rom_addr_nxt = srl_pkg::BLANK_LO; blank_nxt = 1'b1;
                  end
               end
            end
         end
         S_BLANK: begin
            // scan the top area, one byte per cycle
            if (rom_byte != srl_pkg::BLANK_FILL) blank_nxt = 1'b0;
            if (rom_addr_r == srl_pkg::BLANK_HI) begin
               if (blank_nxt) st_nxt = S_HUNT; // R7
               else begin
                  rom_addr_nxt = pcnt_adr_r; st_nxt = S_PCNT;
               end
            end else rom_addr_nxt = rom_addr_r + 16'h0001;
         end
         S_PCNT: begin
            pw_n_nxt = rom_byte; rom_addr_nxt = pcmp_adr_r;
            st_nxt = (rom_byte == 8'h00 || rom_byte > 8'(srl_pkg::PW_MAX)) ? S_HALT : S_PW; // R8
         end
         S_PW: begin
            if (lnk.h2d_valid) begin
               if (lnk.h2d_err || b != rom_byte) st_nxt = S_HALT; // R6 R8
               else begin
                  rom_addr_nxt = rom_addr_r + 16'h0001;
                  pw_n_nxt = pw_n_r - 8'h01;
                  if (pw_n_r == 8'h01) st_nxt = S_HUNT;
               end
            end
         end
         S_HUNT: begin
            if (lnk.h2d_valid && !lnk.h2d_err && b == srl_pkg::START_MARK) begin // R11 R13
               idx_nxt = 3'h0; rsum_nxt = 8'h00; st_nxt = S_REC;
            end
         end
         S_REC: begin
            // idx: 0 len, 1 adr hi, 2 adr lo, 3 type, 4 data, 5 checksum
            if (lnk.h2d_valid) begin
               rsum_nxt = rsum_r + b;
               if (lnk.h2d_err) st_nxt = S_HALT; // R14
               else case (idx_r)
                  3'h0: begin reclen_nxt = b; idx_nxt = 3'h1; end // R12
                  3'h1: begin radr_nxt[15:8] = b; idx_nxt = 3'h2; end
                  3'h2: begin radr_nxt[7:0] = b; idx_nxt = 3'h3; end
                  3'h3: begin
                     rtype_nxt = b;
                     if (b != srl_pkg::REC_DATA && b != srl_pkg::REC_END) st_nxt = S_HALT; // R14
                     else idx_nxt = (reclen_r == 8'h00) ? 3'h5 : 3'h4;
                     if (b == srl_pkg::REC_DATA && !have_first_r) begin
                        first_nxt = radr_r; have_first_nxt = 1'b1; // R19
                     end
                  end
                  3'h4: begin
                     sum_nxt = sum_r + {8'h00, b};
                     radr_nxt = radr_r + 16'h0001;
                     reclen_nxt = reclen_r - 8'h01;
                     if (reclen_r == 8'h01) idx_nxt = 3'h5;
                  end
                  default: begin
                     if (rsum_nxt != 8'h00) st_nxt = S_HALT; // R14
                     else if (rtype_r == srl_pkg::REC_END) begin
                        tx_nxt = sum_r[15:8]; txv_nxt = 1'b1; st_nxt = S_SUMH; // R15 R17
                     end else st_nxt = S_HUNT;
                  end
               endcase
            end
         end
         S_SUMH: begin
            if (!txv_r && !lnk.d2h_busy) begin
               tx_nxt = sum_r[7:0]; txv_nxt = 1'b1; go_nxt = 1'b1; st_nxt = S_HALT; // R17 R19
            end
         end
         S_ERR: begin
            // error code sent three times, then silence
            if (!txv_r && !lnk.d2h_busy) begin
               if (ecnt_r == srl_pkg::ERR_REPEAT) st_nxt = S_HALT; // R2 R3
               else begin
                  tx_nxt = err_code_r; txv_nxt = 1'b1; ecnt_nxt = ecnt_r + 2'h1;
               end
            end
         end
         default: ; // halt: only resetn leaves it // R8
      endcase
      // halt flag taken from a flop, same timing as the state it mirrors
      halted_nxt = (st_nxt == S_HALT) && !go_nxt; // R8
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r <= S_MATCH; idx_r <= 3'h0; pcnt_adr_r <= 16'h0000; pcmp_adr_r <= 16'h0000;
         pw_n_r <= 8'h00; rom_addr_r <= 16'h0000; reclen_r <= 8'h00; rtype_r <= 8'h00;
         rsum_r <= 8'h00; radr_r <= 16'h0000; sum_r <= 16'h0000; first_r <= 16'h0000;
         have_first_r <= 1'b0; blank_r <= 1'b0; tx_r <= 8'h00; txv_r <= 1'b0;
         go_r <= 1'b0; ecnt_r <= 2'h0; err_code_r <= 8'h00;
         div_r <= srl_pkg::INIT_DIV_W; pend_div_r <= 16'h0000; pend_r <= 1'b0;
         halted_r <= 1'b0;
      end else begin
         st_r <= st_nxt; idx_r <= idx_nxt; pcnt_adr_r <= pcnt_adr_nxt;
         pcmp_adr_r <= pcmp_adr_nxt; pw_n_r <= pw_n_nxt; rom_addr_r <= rom_addr_nxt;
         reclen_r <= reclen_nxt; rtype_r <= rtype_nxt; rsum_r <= rsum_nxt;
         radr_r <= radr_nxt; sum_r <= sum_nxt; first_r <= first_nxt;
         have_first_r <= have_first_nxt; blank_r <= blank_nxt; tx_r <= tx_nxt;
         txv_r <= txv_nxt; go_r <= go_nxt; ecnt_r <= ecnt_nxt;
         err_code_r <= err_code_nxt; div_r <= div_nxt;
         pend_div_r <= pend_div_nxt; pend_r <= pend_nxt;
         halted_r <= halted_nxt;
      end
   end

   assign lnk.d2h_valid = txv_r;
   assign lnk.d2h_data  = tx_r;
   assign lnk.d2h_busy  = txv_r;
   assign lnk.baud_div  = div_r;
   assign rom_addr      = rom_addr_r;
   assign halted        = halted_r;
   assign run_go        = go_r;
   assign run_addr      = first_r;
   assign image_checksum_word = sum_r;
endmodule // srl_dev

// file: hw/srl_ctrl.sv
// srl_ctrl: external controller end; drives the load sequence from a user byte feed
// assumes: user supplies the image bytes (passwords then hex records) in order
`timescale 1ns/1ps
module srl_ctrl (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // link
   srl_if.ctrl              lnk,
   // user side
   input  wire logic        start,
   input  wire logic [7:0]  cmd_byte,
   input  wire logic [31:0] addr_words,
   input  wire logic        img_valid,
   input  wire logic [7:0]  img_data,
   input  wire logic        img_last,
   output logic             img_ready,
   output logic             done,
   output logic [15:0]      sum_seen
);
   typedef enum logic [6:0] {
      C_IDLE = 7'h01, C_MATCH = 7'h02, C_BAUD = 7'h04, C_CMD = 7'h08,
      C_ADR  = 7'h10, C_IMG   = 7'h20, C_SUM  = 7'h40
   } srl_cst_t;
   srl_cst_t    st_r, st_nxt;
   logic [7:0]  tx_r, tx_nxt;
   logic        txv_r, txv_nxt, rdy_r, rdy_nxt, done_r, done_nxt, hi_r, hi_nxt;
   logic [1:0]  idx_r, idx_nxt;
   logic [15:0] sum_r, sum_nxt, gap_r, gap_nxt;

   // controller sequence next state
   always_comb begin
      st_nxt = st_r; tx_nxt = tx_r; txv_nxt = 1'b0; rdy_nxt = 1'b0;
      done_nxt = done_r; hi_nxt = hi_r; idx_nxt = idx_r; sum_nxt = sum_r;
      gap_nxt = gap_r;
      case (st_r)
         C_IDLE: if (start) begin
            st_nxt = C_MATCH; gap_nxt = 16'h0000; done_nxt = 1'b0;
         end
         C_MATCH: begin
            // resend match byte each bit-rate gap until echoed
            if (lnk.d2h_valid && lnk.d2h_data == srl_pkg::MATCH_BYTE) begin
               st_nxt = C_BAUD; tx_nxt = srl_pkg::BAUD_9600; txv_nxt = 1'b1; // R1
            end else if (gap_r == 16'h0000) begin
               tx_nxt = srl_pkg::MATCH_BYTE; txv_nxt = 1'b1; gap_nxt = lnk.baud_div; // R20
            end else gap_nxt = gap_r - 16'h0001;
         end
         C_BAUD: if (lnk.d2h_valid) begin
            if (lnk.d2h_data == srl_pkg::BAUD_9600) begin
               st_nxt = C_CMD; tx_nxt = cmd_byte; txv_nxt = 1'b1; // R3
            end else st_nxt = C_IDLE;
         end
         C_CMD: if (lnk.d2h_valid) begin
            if (lnk.d2h_data == cmd_byte) begin
               st_nxt = C_ADR; idx_nxt = 2'h0;
            end else st_nxt = C_IDLE;
         end
         C_ADR: begin
            // count address then compare address, high byte first
            tx_nxt = addr_words[8'(31) - {idx_r, 3'h0} -: 8]; txv_nxt = 1'b1; // R4 R5
            idx_nxt = idx_r + 2'h1;
            if (idx_r == 2'h3) begin
               st_nxt = C_IMG; gap_nxt = srl_pkg::SCAN_WAIT;
            end
         end
         C_IMG: begin
            // feed stays closed while the device scans its top area, or bytes are lost
            if (gap_r != 16'h0000) gap_nxt = gap_r - 16'h0001;
            else rdy_nxt = 1'b1;
            if (img_valid && rdy_r) begin
               tx_nxt = img_data; txv_nxt = 1'b1;
               if (img_last) begin
                  st_nxt = C_SUM; rdy_nxt = 1'b0; hi_nxt = 1'b1; // R10 R16
               end
            end
         end
         C_SUM: if (lnk.d2h_valid) begin
            if (hi_r) begin
               sum_nxt[15:8] = lnk.d2h_data; hi_nxt = 1'b0; // R18
            end else begin
               sum_nxt[7:0] = lnk.d2h_data; done_nxt = 1'b1; st_nxt = C_IDLE;
            end
         end
         default: st_nxt = C_IDLE;
      endcase
   end

   // controller registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r <= C_IDLE; tx_r <= 8'h00; txv_r <= 1'b0; rdy_r <= 1'b0; done_r <= 1'b0;
         hi_r <= 1'b0; idx_r <= 2'h0; sum_r <= 16'h0000; gap_r <= 16'h0000;
      end else begin
         st_r <= st_nxt; tx_r <= tx_nxt; txv_r <= txv_nxt; rdy_r <= rdy_nxt;
         done_r <= done_nxt; hi_r <= hi_nxt; idx_r <= idx_nxt; sum_r <= sum_nxt;
         gap_r <= gap_nxt;
      end
   end

   assign lnk.h2d_valid = txv_r;
   assign lnk.h2d_data  = tx_r;
   assign lnk.h2d_err   = 1'b0;
   assign img_ready     = rdy_r;
   assign done          = done_r;
   assign sum_seen      = sum_r;
endmodule // srl_ctrl

// file: sim/srl_chk.sv
// srl_chk: timing and order checks on the link between the two loader ends
// assumes: sees only the interface signals; one clock, sync active-low reset
`timescale 1ns/1ps
module srl_chk (
   // clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // controller to device
   input wire logic        h2d_valid,
   input wire logic [7:0]  h2d_data,
   input wire logic        h2d_err,
   // device to controller
   input wire logic        d2h_valid,
   input wire logic [7:0]  d2h_data,
   input wire logic        d2h_busy,
   input wire logic [15:0] baud_div
);
   logic [2:0] tx_cnt_r, tx_cnt_nxt;
   logic [7:0] rx_cnt_r, rx_cnt_nxt;
   logic [7:0] op_r, op_nxt;
   logic       sess;

   // a load session starts once the third device byte echoed the load command
   assign sess = (tx_cnt_r >= 3'h3) && (op_r == srl_pkg::OP_RAM_LOAD);

   // byte counters; reset handled here so the flops only register
   always_comb begin
      tx_cnt_nxt = tx_cnt_r;
      rx_cnt_nxt = rx_cnt_r;
      op_nxt = op_r;
      if (d2h_valid && tx_cnt_r != 3'h7) tx_cnt_nxt = tx_cnt_r + 3'h1;
      if (d2h_valid && tx_cnt_r == 3'h2) op_nxt = d2h_data;
      if (h2d_valid && sess && rx_cnt_r != 8'hff) rx_cnt_nxt = rx_cnt_r + 8'h1;
      if (!resetn) begin
         tx_cnt_nxt = 3'h0;
         rx_cnt_nxt = 8'h00;
         op_nxt = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      tx_cnt_r <= tx_cnt_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      op_r <= op_nxt;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // three error strobes two cycles apart; nothing after the third is checked
   sequence s_err3(logic [7:0] code);
      d2h_valid && d2h_data == code ##2 d2h_valid && d2h_data == code
         ##2 d2h_valid && d2h_data == code;
   endsequence

   property p_match_echo;
      h2d_valid && !h2d_err && tx_cnt_r == 3'h0 && h2d_data == srl_pkg::MATCH_BYTE
         |=> d2h_valid && d2h_data == srl_pkg::MATCH_BYTE;
   endproperty
   a_match_echo: assert property (p_match_echo) else $error("match byte not echoed");
   property p_first_echo;
      d2h_valid && tx_cnt_r == 3'h0
         |-> d2h_data == srl_pkg::MATCH_BYTE && $past(h2d_data) == srl_pkg::MATCH_BYTE;
   endproperty
   a_first_echo: assert property (p_first_echo) else $error("first byte not a match echo");
   property p_baud_echo;
      h2d_valid && !h2d_err && tx_cnt_r == 3'h1 && h2d_data == srl_pkg::BAUD_9600
         |=> d2h_valid && d2h_data == srl_pkg::BAUD_9600;
   endproperty
   a_baud_echo: assert property (p_baud_echo) else $error("baud code not echoed");
   property p_baud_hold;
      tx_cnt_r < 3'h2 |-> baud_div == srl_pkg::INIT_DIV_W;
   endproperty
   a_baud_hold: assert property (p_baud_hold) else $error("divider moved before echo");
   property p_cmd_echo;
      h2d_valid && !h2d_err && tx_cnt_r == 3'h2 && h2d_data == srl_pkg::OP_RAM_LOAD
         |=> d2h_valid && d2h_data == srl_pkg::OP_RAM_LOAD;
   endproperty
   a_cmd_echo: assert property (p_cmd_echo) else $error("command not echoed");
   property p_cmd_err;
      h2d_valid && !h2d_err && tx_cnt_r == 3'h2 && h2d_data != srl_pkg::OP_RAM_LOAD
         |-> ##[1:4] s_err3(srl_pkg::ERR_OPCMD);
   endproperty
   a_cmd_err: assert property (p_cmd_err) else $error("bad command code sequence");
   property p_addr_quiet;
      sess && rx_cnt_r <= 8'h04 |-> !d2h_valid;
   endproperty
   a_addr_quiet: assert property (p_addr_quiet) else $error("reply to address byte");
   property p_sum_pair;
      d2h_valid && sess && tx_cnt_r == 3'h3
         |=> !d2h_valid ##[1:1000] (d2h_valid && tx_cnt_r == 3'h4);
   endproperty
   a_sum_pair: assert property (p_sum_pair) else $error("checksum low byte missing");
   property p_sum_last;
      sess && tx_cnt_r == 3'h5 |-> !d2h_valid;
   endproperty
   a_sum_last: assert property (p_sum_last) else $error("byte after checksum");
endmodule // srl_chk

// file: sim/serial_ram_loader_tb.sv
// serial_ram_loader_tb: both loader ends joined, plus a lone device driven by hand
// assumes: 100 MHz clock; rom modelled as a 64k byte array read by address
`timescale 1ns/1ps
module serial_ram_loader_tb;
   typedef logic [7:0] srl_bq_t [$];
   logic        clk, resetn, secure_en, start, img_valid, img_last, img_ready;
   logic        done, halted, halted2, run_go;
   logic [7:0]  cmd_byte, img_data;
   logic [31:0] addr_words;
   logic [15:0] rom_addr, rom_addr2, run_addr, sum_word, sum_seen, exp_sum;
   logic [7:0]  rom_mem [0:65535];
   srl_bq_t     img, q2, nil;
   int          failures, tests_run, cyc;

   srl_if lnk ();
   srl_if lnk2 ();
   srl_dev u_srl_dev (.clk(clk), .resetn(resetn), .lnk(lnk), .secure_en(secure_en),
      .rom_byte(rom_mem[rom_addr]), .rom_addr(rom_addr), .halted(halted), .run_go(run_go),
      .run_addr(run_addr), .image_checksum_word(sum_word));
   srl_ctrl u_srl_ctrl (.clk(clk), .resetn(resetn), .lnk(lnk), .start(start),
      .cmd_byte(cmd_byte), .addr_words(addr_words), .img_valid(img_valid),
      .img_data(img_data), .img_last(img_last), .img_ready(img_ready), .done(done),
      .sum_seen(sum_seen));
   // second device faces the bench directly so faults can be injected
   srl_dev u_srl_dev_2 (.clk(clk), .resetn(resetn), .lnk(lnk2), .secure_en(secure_en),
      .rom_byte(rom_mem[rom_addr2]), .rom_addr(rom_addr2), .halted(halted2), .run_go(),
      .run_addr(), .image_checksum_word());
   srl_chk u_srl_chk (.clk(clk), .resetn(resetn), .h2d_valid(lnk.h2d_valid),
      .h2d_data(lnk.h2d_data), .h2d_err(lnk.h2d_err), .d2h_valid(lnk.d2h_valid),
      .d2h_data(lnk.d2h_data), .d2h_busy(lnk.d2h_busy), .baud_div(lnk.baud_div));

   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard and capture of the lone device's replies
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (lnk2.d2h_valid === 1'b1) q2.push_back(lnk2.d2h_data);
      if (cyc == 60000) begin
         failures++;
         summarize();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic do_reset();
      @(negedge clk);
      resetn = 1'b0;
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      q2.delete();
   endtask

   // one record: start mark, length, address, type, data, two's complement sum
   task automatic rec(input logic [7:0] typ, input logic [15:0] adr, input srl_bq_t d,
                      input logic [7:0] bad);
      logic [7:0] s;
      s = 8'(d.size()) + adr[15:8] + adr[7:0] + typ;
      img.push_back(srl_pkg::START_MARK);
      img.push_back(8'(d.size()));
      img.push_back(adr[15:8]);
      img.push_back(adr[7:0]);
      img.push_back(typ);
      foreach (d[i]) begin
         img.push_back(d[i]);
         s += d[i];
         if (typ == srl_pkg::REC_DATA) exp_sum += 16'(d[i]);
      end
      img.push_back(8'h00 - s + bad);
   endtask

   // password string, a stray byte to skip, two data records, end record
   task automatic std_img(input srl_bq_t pw, input logic [7:0] bad);
      img = pw;
      exp_sum = 16'h0000;
      img.push_back(8'h11);
      rec(srl_pkg::REC_DATA, 16'h0100, '{8'h01, 8'h02, 8'h03}, 8'h00);
      rec(srl_pkg::REC_DATA, 16'h0200, '{8'hf0, 8'h0f}, bad);
      rec(srl_pkg::REC_END, 16'h0000, nil, 8'h00);
   endtask

   // full session on the joined pair; image fed through the ready handshake
   task automatic session(input logic [7:0] cmd);
      int n;
      do_reset();
      cmd_byte = cmd;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      foreach (img[i]) begin
         img_data = img[i];
         img_last = (i == img.size() - 1);
         img_valid = 1'b1;
         n = 0;
         // ready is looked at mid-cycle, where it is settled for the taking edge
         while (img_ready !== 1'b1 && halted !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
         end
         @(negedge clk);
      end
      img_valid = 1'b0;
      img_last = 1'b0;
      for (n = 0; n < 4000 && done !== 1'b1 && halted !== 1'b1; n++) @(negedge clk);
      repeat (50) @(negedge clk);
   endtask

   // hand-driven bytes to the lone device, one fault optional, replies compared
   task automatic run2(input srl_bq_t bs, input int err_at, input srl_bq_t ex);
      do_reset();
      foreach (bs[i]) begin
         lnk2.h2d_data = bs[i];
         lnk2.h2d_err = (i == err_at);
         lnk2.h2d_valid = 1'b1;
         @(negedge clk);
         lnk2.h2d_valid = 1'b0;
         lnk2.h2d_err = 1'b0;
         lnk2.h2d_data = ~bs[i];
         repeat (40) @(negedge clk);
      end
      chk(16'(q2.size()), 16'(ex.size()));
      foreach (ex[i]) chk({8'h00, q2[i]}, {8'h00, ex[i]});
      chk({15'h0, halted2}, 16'h0001);
   endtask

   // main sequence
   initial begin
      resetn = 1'b0;
      secure_en = 1'b0;
      start = 1'b0;
      cmd_byte = 8'h00;
      addr_words = 32'h1000_1010;
      img_valid = 1'b0;
      img_data = 8'h00;
      img_last = 1'b0;
      lnk2.h2d_valid = 1'b0;
      lnk2.h2d_data = 8'h00;
      lnk2.h2d_err = 1'b0;
      failures = 0;
      tests_run = 0;
      cyc = 0;
      foreach (rom_mem[i]) rom_mem[i] = srl_pkg::BLANK_FILL;
      std_img(nil, 8'h00);
      session(srl_pkg::OP_RAM_LOAD);
      chk({15'h0, done}, 16'h0001);
      chk(sum_seen, exp_sum);
      chk(sum_word, exp_sum);
      chk({15'h0, run_go}, 16'h0001);
      chk(run_addr, 16'h0100);
      chk({8'h00, u_srl_dev.ram[10'h102]}, 16'h0003);
      chk({8'h00, u_srl_dev.ram[10'h201]}, 16'h000f);
      // part no longer blank: count at 1000h, compare string at 1010h
      rom_mem[16'hffe0] = 8'h00;
      rom_mem[16'h1000] = 8'h02;
      rom_mem[16'h1010] = 8'hab;
      rom_mem[16'h1011] = 8'hcd;
      std_img('{8'hab, 8'hcd}, 8'h00);
      session(srl_pkg::OP_RAM_LOAD);
      chk(sum_seen, exp_sum);
      std_img('{8'hab, 8'hce}, 8'h00);
      session(srl_pkg::OP_RAM_LOAD);
      chk({13'h0000, halted, run_go, done}, 16'h0004);
      std_img('{8'hab, 8'hcd}, 8'h00);
      secure_en = 1'b1;
      session(srl_pkg::OP_RAM_LOAD);
      chk({14'h0000, halted, run_go}, 16'h0002);
      secure_en = 1'b0;
      session(8'h61);
      chk({14'h0000, halted, run_go}, 16'h0002);
      std_img('{8'hab, 8'hcd}, 8'h01);
      session(srl_pkg::OP_RAM_LOAD);
      chk({14'h0000, halted, run_go}, 16'h0002);
      chk(sum_seen, 16'h0000);
      foreach (rom_mem[i]) rom_mem[i] = srl_pkg::BLANK_FILL;
      run2('{8'h55, 8'h5a, 8'h30, 8'h5a}, -1, '{8'h5a, 8'h62, 8'h62, 8'h62});
      run2('{8'h5a, 8'h28}, 1, '{8'h5a, 8'ha1, 8'ha1, 8'ha1});
      run2('{8'h5a, 8'h28, 8'h60}, 2, '{8'h5a, 8'h28, 8'ha3, 8'ha3, 8'ha3});
      run2('{8'h5a, 8'h28, 8'h60, 8'h10}, 3, '{8'h5a, 8'h28, 8'h60});
      run2('{8'h5a, 8'h28, 8'h60, 8'h10, 8'h00, 8'h10, 8'h10, 8'h3a, 8'h01}, 8,
           '{8'h5a, 8'h28, 8'h60});
      summarize();
   end
endmodule // serial_ram_loader_tb
